// >>> src/cac_top.v
/*
 * Five-module compare array on one shared 16-bit counter: toggle
 * outputs, 8-bit pulse-width outputs and a watchdog on module 4,
 * with an APB register slave. Assumes one clock, pclk, and an APB
 * master that keeps the bus protocol; the watchdog reset output is
 * wired into the system's internal reset tree only.
 */
// Chosen here: the register offsets and the APB slave port.
// Behaviour
// RULE1 - High-speed mode inverts the module pin on each counter match
// RULE2 - High-speed mode needs toggle, match-flag and comparator enable bits set
// RULE3 - Every module can do pulse-width output on one shared counter
// RULE4 - Each module's duty comes from its own active low compare byte
// RULE5 - Pulse-width pin low while counter low byte below active byte, else high
// RULE6 - On low byte wrap FF to 00 copy upper byte to active byte
// RULE7 - Pulse-width mode needs pulse-width and comparator enable bits set
// RULE8 - Only module 4 has the watchdog; otherwise it keeps all modes
// RULE9 - Watchdog raises internal reset when its 16-bit compare equals counter
// RULE10 - Watchdog reset acts on internal logic only, never the reset pin
// RULE11 - Software rewrites module 4 compare value to hold off the reset
// RULE12 - Software may rewrite the shared counter instead, disturbing others
// RULE13 - Clearing watchdog enable before a match suppresses the reset
// RULE14 - Software services the watchdog within 2^16 counter counts
// RULE15 - With match-flag enable, a match sets the module event flag
// RULE16 - Event flag requests an interrupt only with its enable bit set
// RULE17 - Counter advances only while the run bit is set
// RULE18 - Counter is 16 bits of high and low byte, wrapping to zero
// RULE19 - Upper to active byte reload applies to pulse-width modules only
`include "cac_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module cac_top (
    input wire pclk, // System clock, 40 MHz
    input wire presetn, // Asynchronous reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error on unmapped address
    output reg [4:0] compare_output_pin, // Module output pins
    output reg module_irq_req, // Event interrupt request
    output reg wd_sys_reset // Internal reset pulse
);

    ////////////////////////////////////////////////////////////////
    // State

    reg [15:0] cnt_q; // Shared counter, high and low byte
    reg run_q; // Counter run bit
    reg ovf_q; // Counter overflow flag
    reg [4:0] flag_q; // Module event flags
    reg watchdog_enable_bit_q; // Watchdog enable bit
    reg [7:0] mode_q [0:4]; // Module mode registers
    reg [7:0] upper_q [0:4]; // Upper compare bytes
    reg [7:0] act_q [0:4]; // Active low compare bytes

    reg [15:0] cnt_d;
    reg run_d;
    reg ovf_d;
    reg [4:0] flag_d;
    reg watchdog_enable_bit_d;
    reg [4:0] pin_d;
    reg irq_d;
    reg wd_d;
    reg [31:0] rdata_d;
    reg err_d;
    reg ready_d;

    // Mode decode helpers
    function hs_mode;
        input [7:0] m;
        begin
            hs_mode = m[`CAC_COMPARATOR_ENABLE_BIT_BIT] & m[`CAC_MAT_BIT] & m[`CAC_TOG_BIT]
                & ~m[`CAC_PWM_BIT];
        end
    endfunction

    function pwm_mode;
        input [7:0] m;
        begin
            pwm_mode = m[`CAC_COMPARATOR_ENABLE_BIT_BIT] & m[`CAC_PWM_BIT];
        end
    endfunction

    // Register address decode: module index of a banked register
    function [2:0] bank_idx;
        input [7:0] a;
        input [7:0] base;
        reg [7:0] off;
        begin
            off = a - base;
            bank_idx = off[4:2];
        end
    endfunction

    function in_bank;
        input [7:0] a;
        input [7:0] base;
        reg [7:0] off;
        begin
            off = a - base;
            in_bank = (a >= base) && (off[1:0] == 2'b00)
                && (off[7:2] < `CAC_NMOD);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Bus decode

    wire wr_en = psel & penable & pready & pwrite;
    wire rd_setup = psel & ~penable;
    wire wr_ctrl = wr_en & (paddr == `CAC_CTRL_OFF);
    wire wr_cnt = wr_en & (paddr == `CAC_CNT_OFF);
    wire wr_wdt = wr_en & (paddr == `CAC_WDT_OFF);
    wire wr_mode = wr_en & in_bank(paddr, `CAC_MODE_OFF);
    wire wr_cmp = wr_en & in_bank(paddr, `CAC_CMP_OFF);
    wire [2:0] widx_mode = bank_idx(paddr, `CAC_MODE_OFF);
    wire [2:0] widx_cmp = bank_idx(paddr, `CAC_CMP_OFF);

    ////////////////////////////////////////////////////////////////
    // Counter events

    wire tick = run_q; // RULE17
    wire low_wrap = tick & (cnt_q[7:0] == `CAC_LOW_MAX);
    wire full_wrap = tick & (cnt_q == `CAC_CNT_MAX);

    // Per-module match: counter equals compare while the counter runs and comparator is on
    reg [4:0] match;
    // One loop index per process, so that no variable has two drivers
    integer k;
    integer kf;
    integer kp;
    always @* begin
        for (k = 0; k < `CAC_NMOD; k = k + 1) begin
            match[k] = tick & mode_q[k][`CAC_COMPARATOR_ENABLE_BIT_BIT]
                & (cnt_q == {upper_q[k], act_q[k]});
        end
    end

    ////////////////////////////////////////////////////////////////
    // Next state of counter, control and flags

    always @* begin
        cnt_d = cnt_q;
        if (tick) begin
            cnt_d = cnt_q + 16'h0001; // RULE18
        end
        if (wr_cnt) begin
            cnt_d = pwdata[15:0]; // RULE12
        end
        run_d = run_q;
        ovf_d = ovf_q;
        flag_d = flag_q;
        if (wr_ctrl) begin
            run_d = pwdata[`CAC_RUN_BIT]; // RULE17
            if (pwdata[`CAC_OVF_BIT]) begin
                ovf_d = 1'b0;
            end
            flag_d = flag_q & ~pwdata[4:0];
        end
        // Hardware set wins over a clear in the same cycle
        if (full_wrap) begin
            ovf_d = 1'b1;
        end
        for (kf = 0; kf < `CAC_NMOD; kf = kf + 1) begin
            if (match[kf] & mode_q[kf][`CAC_MAT_BIT]) begin
                flag_d[kf] = 1'b1; // RULE15
            end
        end
        watchdog_enable_bit_d = wr_wdt ? pwdata[`CAC_WATCHDOG_ENABLE_BIT_BIT] : watchdog_enable_bit_q;
    end

    ////////////////////////////////////////////////////////////////
    // Next state of pins, interrupt and watchdog

    always @* begin
        irq_d = 1'b0;
        for (kp = 0; kp < `CAC_NMOD; kp = kp + 1) begin
            pin_d[kp] = compare_output_pin[kp];
            if (pwm_mode(mode_q[kp])) begin // RULE7
                // Low below the active byte, high at or above it
                pin_d[kp] = (cnt_d[7:0] >= act_q[kp]); // RULE3 RULE4 RULE5
            end else if (hs_mode(mode_q[kp]) & match[kp]) begin // RULE2
                pin_d[kp] = ~compare_output_pin[kp]; // RULE1
            end
            if (flag_d[kp] & mode_q[kp][`CAC_ECCF_BIT]) begin
                irq_d = 1'b1; // RULE16
            end
        end
        // Watchdog on module 4 only, needs comparator and match enables
        wd_d = watchdog_enable_bit_q & match[`CAC_WD_MOD] // RULE8 RULE9 RULE13
            & mode_q[`CAC_WD_MOD][`CAC_MAT_BIT]
            & ~mode_q[`CAC_WD_MOD][`CAC_PWM_BIT];
    end

    ////////////////////////////////////////////////////////////////
    // Read mux and answer

    always @* begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == `CAC_CTRL_OFF) begin
            rdata_d[`CAC_OVF_BIT] = ovf_q;
            rdata_d[`CAC_RUN_BIT] = run_q;
            rdata_d[4:0] = flag_q;
        end else if (paddr == `CAC_CNT_OFF) begin
            rdata_d[15:0] = cnt_q;
        end else if (paddr == `CAC_WDT_OFF) begin
            rdata_d[`CAC_WATCHDOG_ENABLE_BIT_BIT] = watchdog_enable_bit_q;
        end else if (in_bank(paddr, `CAC_MODE_OFF)) begin
            rdata_d[7:0] = mode_q[widx_mode];
        end else if (in_bank(paddr, `CAC_CMP_OFF)) begin
            rdata_d[15:0] = {upper_q[widx_cmp], act_q[widx_cmp]};
        end else begin
            err_d = 1'b1;
        end
        ready_d = rd_setup;
    end

    ////////////////////////////////////////////////////////////////
    // Counter, control and bus registers

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `CAC_RST_16;
            run_q <= 1'b0;
            ovf_q <= 1'b0;
            flag_q <= 5'h00;
            watchdog_enable_bit_q <= 1'b0;
            compare_output_pin <= 5'h00;
            module_irq_req <= 1'b0;
            wd_sys_reset <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            ovf_q <= ovf_d;
            flag_q <= flag_d;
            watchdog_enable_bit_q <= watchdog_enable_bit_d;
            compare_output_pin <= pin_d;
            module_irq_req <= irq_d;
            // Pulse to the internal reset tree; no external pin is driven
            wd_sys_reset <= wd_d; // RULE10
            pready <= ready_d;
            if (rd_setup) begin
                prdata <= rdata_d;
                pslverr <= err_d;
            end else if (!psel) begin
                pslverr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Module mode and compare registers

    integer m;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (m = 0; m < `CAC_NMOD; m = m + 1) begin
                mode_q[m] <= `CAC_RST_8;
                upper_q[m] <= `CAC_RST_8;
                act_q[m] <= `CAC_RST_8;
            end
        end else begin
            for (m = 0; m < `CAC_NMOD; m = m + 1) begin
                if (wr_mode && widx_mode == m) begin
                    mode_q[m] <= pwdata[7:0] & `CAC_MODE_MASK;
                end
                if (wr_cmp && widx_cmp == m) begin
                    // Software rewrite holds off the watchdog
                    upper_q[m] <= pwdata[15:8]; // RULE11
                    act_q[m] <= pwdata[7:0];
                end else if (low_wrap & pwm_mode(mode_q[m])) begin
                    act_q[m] <= upper_q[m]; // RULE6 RULE19
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> src/cac_defines.vh
/*
 * Register map, field positions and reset values of the counter
 * array compare block. Assumes a 32-bit APB with byte addresses.
 */
`ifndef CAC_DEFINES_VH
`define CAC_DEFINES_VH

// Register byte offsets
`define CAC_CTRL_OFF 8'h00
`define CAC_CNT_OFF 8'h04
`define CAC_WDT_OFF 8'h08
`define CAC_MODE_OFF 8'h10
`define CAC_CMP_OFF 8'h30
`define CAC_STEP 8'h04

// Control register fields
`define CAC_OVF_BIT 7
`define CAC_RUN_BIT 6

// Mode register fields
`define CAC_COMPARATOR_ENABLE_BIT_BIT 6
`define CAC_MAT_BIT 3
`define CAC_TOG_BIT 2
`define CAC_PWM_BIT 1
`define CAC_ECCF_BIT 0
`define CAC_MODE_MASK 8'h7f

// Watchdog enable field and the module that carries it
`define CAC_WATCHDOG_ENABLE_BIT_BIT 0
`define CAC_WD_MOD 4

// Sizes and reset values
`define CAC_NMOD 5
`define CAC_RST_8 8'h00
`define CAC_RST_16 16'h0000
`define CAC_LOW_MAX 8'hff
`define CAC_CNT_MAX 16'hffff

`endif

// >>> dv/cac_top_assertions.sv
/* Port checker for the compare array block: APB timing, watchdog
   pulse shape, reset state and quiet pins on a stopped counter.
   Assumes binding onto cac_top with its single clock pclk. */
`timescale 1ns/1ps
`default_nettype none
module cac_chk (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB address
    input wire [31:0] pwdata, // APB write data
    input wire [31:0] prdata, // APB read data
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire [4:0] compare_output_pin, // Module pins
    input wire module_irq_req, // Interrupt request
    input wire wd_sys_reset // Watchdog reset pulse
);
    reg run_q;
    // Mirror of the counter run bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) run_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == 8'h00) run_q <= pwdata[6];
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_quiet; (!run_q && !psel) [*4]; endsequence
    property p_ready_next; psel && !penable |=> pready; endproperty
    property p_ready_one; pready |=> !pready; endproperty
    property p_ready_access; pready |-> psel && penable; endproperty
    property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
    property p_rst_out; $rose(presetn) |-> compare_output_pin == 5'h0 && !module_irq_req; endproperty
    property p_wd_pulse; wd_sys_reset |=> !wd_sys_reset; endproperty
    property p_stop_pins; s_quiet |-> $stable(compare_output_pin); endproperty
    property p_stop_events; s_quiet |-> !wd_sys_reset && $stable(module_irq_req); endproperty
    a_ready_next: assert property (p_ready_next) else $error("no pready after setup");
    a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
    a_ready_access: assert property (p_ready_access) else $error("pready outside access");
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    a_rst_out: assert property (p_rst_out) else $error("outputs active after reset");
    a_wd_pulse: assert property (p_wd_pulse) else $error("watchdog pulse too long");
    a_stop_pins: assert property (p_stop_pins) else $error("pins move when stopped");
    a_stop_events: assert property (p_stop_events) else $error("events when stopped");
    c_wd: cover property (wd_sys_reset);
    c_irq: cover property (module_irq_req);
    c_err: cover property (pready && pslverr);
endmodule
bind cac_top cac_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_output_pin(compare_output_pin),
    .module_irq_req(module_irq_req), .wd_sys_reset(wd_sys_reset));
`default_nettype wire

// >>> dv/cac_load.sv
/* Load on the compare output pins: counts every level change.
   Assumes the pins are sampled on pclk. */
`timescale 1ns/1ps
`default_nettype none
module cac_load (
    input wire pclk, // Clock
    input wire presetn, // Reset, active low
    input wire [4:0] pins, // Compare output pins
    output reg [15:0] changes // Level changes seen
);
    reg [4:0] last_q;
    wire [4:0] diff = pins ^ last_q; // Pins that changed this cycle
    // Count changes on all pins together
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 5'h0;
            changes <= 16'h0;
        end else begin
            last_q <= pins;
            changes <= changes + {15'h0, diff[0]} + {15'h0, diff[1]} + {15'h0, diff[2]}
                + {15'h0, diff[3]} + {15'h0, diff[4]};
        end
    end
endmodule
`default_nettype wire

// >>> dv/cac_top_tb.sv
/* Self-checking bench of the compare array: registers, toggle,
   pulse-width and watchdog modes. Assumes cac_top and cac_load. */
`timescale 1ns/1ps
`default_nettype none
module cac_top_tb;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    reg [7:0] paddr = 0, i;
    reg [31:0] pwdata = 0, seed = 32'h574bf06e, rd;
    reg [15:0] v, base;
    reg [39:0] mds = 40'h4c_4d_04_44_4c;
    wire [31:0] prdata;
    wire pready, pslverr, module_irq_req, wd_sys_reset;
    wire [4:0] pins;
    wire [15:0] nchg;
    integer n_fail = 0, tests_run = 0, nwd = 0, n0;
    always #12.5 pclk = ~pclk;
    cac_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compare_output_pin(pins), .module_irq_req(module_irq_req),
        .wd_sys_reset(wd_sys_reset));
    cac_load u_load (.pclk(pclk), .presetn(presetn), .pins(pins), .changes(nchg));
    // Count watchdog pulses
    always @(posedge pclk) if (wd_sys_reset === 1'b1) nwd = nwd + 1;
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // One APB transfer, request held until pready; release left to idle
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            // Wait for the answer; only the hang guard process ends a hang
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
        end
    endtask
    task idle(input integer n);
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            repeat (n) @(posedge pclk);
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task end_sim;
        begin
            $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #500000;
        n_fail = n_fail + 1;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values and unmapped read
        for (i = 0; i < 5; i = i + 1) begin
            apb(0, 8'h10 + 8'h04 * i, 0); chk("mode reset", 0, rd);
            apb(0, 8'h30 + 8'h04 * i, 0); chk("compare reset", 0, rd);
        end
        apb(0, 8'h0c, 0); chk("unmapped err", 1, {31'h0, err}); chk("unmapped data", 0, rd);
        // Two counts across the top of the counter
        apb(1, 8'h04, 32'hffff); apb(1, 8'h00, 32'h40); apb(1, 8'h00, 0);
        apb(0, 8'h04, 0); idle(6); chk("counter wrap", 1, rd);
        // Toggle mode with a random match value; module 1 lacks match enable, module 2 comparator and match enables
        seed = xs(seed);
        v = seed[15:0];
        for (i = 0; i < 5; i = i + 1) begin
            apb(1, 8'h10 + 8'h04 * i, {24'h0, mds[8 * i +: 8]});
            apb(1, 8'h30 + 8'h04 * i, {16'h0, v});
        end
        apb(1, 8'h04, {16'h0, v - 16'd30}); idle(3); base = nchg;
        apb(1, 8'h00, 32'h40); idle(45); apb(1, 8'h00, 0); apb(0, 8'h00, 0); idle(6);
        chk("toggle pins", 32'h19, {27'h0, pins});
        chk("pin changes", 3, {16'h0, nchg - base});
        chk("event flags", 32'h19, {27'h0, rd[4:0]});
        chk("irq on", 1, {31'h0, module_irq_req});
        chk("no watchdog", 0, nwd);
        apb(1, 8'h00, 32'h1f); idle(3); chk("irq off", 0, {31'h0, module_irq_req});
        // Pulse-width: module 0 and 4 at own duties, module 1 lacks comparator enable
        apb(1, 8'h10, 32'h42); apb(1, 8'h14, 32'h02); apb(1, 8'h20, 32'h42);
        apb(1, 8'h30, 32'h4080); apb(1, 8'h34, 0); apb(1, 8'h40, 32'h0030);
        apb(1, 8'h04, 32'h0050); idle(6);
        chk("pwm pins", 32'h10, {27'h0, pins & 5'b10011});
        apb(1, 8'h04, 32'h00fe); apb(1, 8'h00, 32'h40); apb(1, 8'h00, 0);
        apb(0, 8'h30, 0); chk("reload", 32'h4040, rd);
        apb(0, 8'h3c, 0); chk("no reload", {16'h0, v}, rd);
        apb(1, 8'h04, 32'h0050); idle(6); chk("pwm new duty", 1, {31'h0, pins[0]});
        // Watchdog: match, disabled, serviced by compare move, serviced by counter move
        apb(1, 8'h20, 32'h48);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1, 8'h40, 32'h0200); apb(1, 8'h08, {31'h0, i != 8'd1}); apb(1, 8'h04, 32'h01f0);
            n0 = nwd;
            apb(1, 8'h00, 32'h40);
            // Service well inside 2^16 counts of the counter
            if (i == 8'd3) apb(1, 8'h04, 32'h0100);
            else apb(1, 8'h40, (i == 8'd2) ? 32'h0300 : 32'h0200);
            idle(40);
            apb(1, 8'h00, 0); idle(6);
            chk("wd pulses", {31'h0, i == 8'd0}, nwd - n0);
        end
        end_sim;
    end
endmodule
`default_nettype wire
